// File: pwm_pkg.sv
package pwm_pkg;
	localparam int CNT_W = 10;
	// apb register offsets (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_DUTY = 8'h08;
	localparam logic [7:0] ADDR_POL = 8'h0c;
	localparam logic [7:0] ADDR_COUNT = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	// field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_IE_BIT = 1;
	localparam int DUTY_OTS_BIT = 12;
	localparam int POL_INV_BIT = 0;
	localparam int STAT_FLAG_BIT = 0;
	// reset values
	localparam logic [CNT_W-1:0] PERIOD_RST = 10'h3ff;
	localparam logic [CNT_W-1:0] DUTY_RST = 10'h200;
	localparam logic [CNT_W-1:0] CNT_START = 10'h000;

	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic pin_a;
		logic pin_a_oe;
		logic pin_b;
		logic pin_b_oe;
	} pwm_pins_s;
endpackage

// File: pwm_match.sv
`timescale 1ns/1ps
// compare unit: two separate equalities, one for the period match and one for the duty match
module pwm_match #(
	parameter int W = 10
) (
	input wire logic [W-1:0] count_i,
	input wire logic [W-1:0] period_i,
	input wire logic [W-1:0] duty_i,
	output logic period_hit_o,
	output logic duty_hit_o
);
	assign period_hit_o = (count_i == period_i);
	assign duty_hit_o = (count_i == duty_i);
endmodule

// File: single_channel_pwm_backlight.sv
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// --------------------------------------------------------------
// Overview of operation
// - period match drives selected output high
// - duty match drives output low
// - counter, period, duty are ten bits
// - period match raises compare-match interrupt
// - period match clears counter to start
// - select bit one routes to output b
// - polarity setting; direct means no inversion
// - counter advances every clock, no prescale
// --------------------------------------------------------------
module single_channel_pwm_backlight #(
	parameter int CNT_W = pwm_pkg::CNT_W
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire pwm_pkg::apb_req_s apb_req_i,
	output pwm_pkg::apb_rsp_s apb_rsp_o,
	output pwm_pkg::pwm_pins_s pins_o,
	output logic period_match_irq_o
);
	typedef struct packed {
		logic run;
		logic irq_en;
		logic flag;
		logic output_terminal_select;
		logic invert;
		logic [CNT_W-1:0] pwm_counter;
		logic [CNT_W-1:0] pwm_period_reg;
		logic [CNT_W-1:0] duty_buffer_reg;
		logic [CNT_W-1:0] duty_active;
		logic wave;
		logic [31:0] prdata;
	} state_s;

	state_s s_q, s_d;
	logic period_hit, duty_hit, wr, rd;

	// --------------------------------------------------------------
	// compare
	// --------------------------------------------------------------
	pwm_match #(.W(CNT_W)) u_match (
		.count_i(s_q.pwm_counter),
		.period_i(s_q.pwm_period_reg),
		.duty_i(s_q.duty_active),
		.period_hit_o(period_hit),
		.duty_hit_o(duty_hit)
	);

	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	// ctrl: bit 0 run, bit 1 interrupt enable
	// period: bits 9:0, counter clears on match
	// duty: bits 9:0 buffer, bit 12 selects output b
	// pol: bit 0 inverts the selected pin
	// count: read only, live counter
	// stat: bit 0 match flag, write one clears
	// unmapped words read zero and ignore writes
	assign wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
	// read data captured in setup so it stands through the access phase
	assign rd = apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite;

	function automatic logic [31:0] zext(input logic [CNT_W-1:0] v);
		zext = {{(32-CNT_W){1'b0}}, v};
	endfunction

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		if (s_q.run) begin
			if (period_hit) begin
				s_d.pwm_counter = pwm_pkg::CNT_START;
				s_d.wave = 1'b1;
				// buffer reaches the compare only here, so no cycle is cut short
				s_d.duty_active = s_q.duty_buffer_reg;
			end else begin
				s_d.pwm_counter = s_q.pwm_counter + 1'b1;
				if (duty_hit) begin
					s_d.wave = 1'b0;
				end
			end
		end
		if (wr) begin
			unique case (apb_req_i.paddr)
				pwm_pkg::ADDR_CTRL: begin
					s_d.run = apb_req_i.pwdata[pwm_pkg::CTRL_RUN_BIT];
					s_d.irq_en = apb_req_i.pwdata[pwm_pkg::CTRL_IE_BIT];
				end
				pwm_pkg::ADDR_PERIOD: s_d.pwm_period_reg = apb_req_i.pwdata[CNT_W-1:0];
				pwm_pkg::ADDR_DUTY: begin
					s_d.duty_buffer_reg = apb_req_i.pwdata[CNT_W-1:0];
					s_d.output_terminal_select = apb_req_i.pwdata[pwm_pkg::DUTY_OTS_BIT];
				end
				pwm_pkg::ADDR_POL: s_d.invert = apb_req_i.pwdata[pwm_pkg::POL_INV_BIT];
				pwm_pkg::ADDR_STAT: begin
					if (apb_req_i.pwdata[pwm_pkg::STAT_FLAG_BIT]) begin
						s_d.flag = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// set after clear so a match in the clearing cycle is kept
		if (s_q.run && period_hit) begin
			s_d.flag = 1'b1;
		end
		if (rd) begin
			unique case (apb_req_i.paddr)
				pwm_pkg::ADDR_CTRL: s_d.prdata = {30'h0000_0000, s_q.irq_en, s_q.run};
				pwm_pkg::ADDR_PERIOD: s_d.prdata = zext(s_q.pwm_period_reg);
				pwm_pkg::ADDR_DUTY: s_d.prdata = {19'h0_0000, s_q.output_terminal_select, 2'b00,
					s_q.duty_buffer_reg};
				pwm_pkg::ADDR_POL: s_d.prdata = {31'h0000_0000, s_q.invert};
				pwm_pkg::ADDR_COUNT: s_d.prdata = zext(s_q.pwm_counter);
				pwm_pkg::ADDR_STAT: s_d.prdata = {31'h0000_0000, s_q.flag};
				default: s_d.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '{run: 1'b0, irq_en: 1'b0, flag: 1'b0, output_terminal_select: 1'b0, invert: 1'b0,
				pwm_counter: pwm_pkg::CNT_START, pwm_period_reg: pwm_pkg::PERIOD_RST,
				duty_buffer_reg: pwm_pkg::DUTY_RST, duty_active: pwm_pkg::DUTY_RST,
				wave: 1'b0, prdata: 32'h0000_0000};
		end else begin
			s_q <= s_d;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	// unselected pin is released, not driven, so the port can serve elsewhere
	logic wave_pol;
	assign wave_pol = s_q.wave ^ s_q.invert;
	assign pins_o.pin_b = s_q.output_terminal_select & wave_pol;
	assign pins_o.pin_b_oe = s_q.output_terminal_select;
	assign pins_o.pin_a = ~s_q.output_terminal_select & wave_pol;
	assign pins_o.pin_a_oe = ~s_q.output_terminal_select;
	assign period_match_irq_o = s_q.flag & s_q.irq_en;
	assign apb_rsp_o.prdata = s_q.prdata;
	// every access completes without wait states
	assign apb_rsp_o.pready = 1'b1;
	assign apb_rsp_o.pslverr = 1'b0;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_period_sets_high: assert property (s_q.run && period_hit |=> s_q.wave)
		else $error("wave not high after period match");
	a_duty_sets_low: assert property (s_q.run && duty_hit && !period_hit |=> !s_q.wave)
		else $error("wave not low after duty match");
	a_counter_clear: assert property (s_q.run && period_hit |=> s_q.pwm_counter == pwm_pkg::CNT_START)
		else $error("counter not cleared");
	a_counter_step: assert property (s_q.run && !period_hit |=> s_q.pwm_counter == $past(s_q.pwm_counter) + 1'b1)
		else $error("counter did not advance");
	a_irq_flag: assert property (s_q.run && period_hit |=> s_q.flag)
		else $error("flag not set on period match");
	a_duty_latch: assert property (s_q.run && period_hit |=> s_q.duty_active == $past(s_q.duty_buffer_reg))
		else $error("duty not loaded at period");
	a_duty_hold: assert property (!(s_q.run && period_hit) |=> $stable(s_q.duty_active))
		else $error("duty changed mid cycle");
	a_pin_route: assert property (s_q.output_terminal_select |-> pins_o.pin_b_oe && !pins_o.pin_a_oe
		&& pins_o.pin_b == (s_q.wave ^ s_q.invert))
		else $error("pin b routing wrong");
	a_width: assert property (s_q.pwm_counter <= s_q.pwm_period_reg || !s_q.run)
		else $error("counter beyond period");

	c_period: cover property (s_q.run && period_hit);
	c_duty_fall: cover property (s_q.run && duty_hit && !period_hit && s_q.wave);
	c_pin_b: cover property (pins_o.pin_b_oe && pins_o.pin_b);
	c_clear_race: cover property (wr && apb_req_i.paddr == pwm_pkg::ADDR_STAT && period_hit && s_q.run);
	c_flag_clear: cover property (s_q.flag ##1 !s_q.flag);

	// --------------------------------------------------------------
	// checks: stop, interrupt, registers and pins
	// --------------------------------------------------------------
	// a stopped counter must not drift, or a restart would open with a short cycle
	a_counter_hold: assert property (!s_q.run |=> $stable(s_q.pwm_counter))
		else $error("counter moved while stopped");
	a_wave_hold: assert property (!s_q.run |=> $stable(s_q.wave))
		else $error("wave moved while stopped");
	a_low_until_period: assert property (s_q.run && !period_hit && !s_q.wave |=> !s_q.wave)
		else $error("wave rose without period match");

	a_irq_raise: assert property (s_q.run && period_hit && s_q.irq_en |=> period_match_irq_o)
		else $error("interrupt not raised on period match");
	a_irq_mask: assert property (!s_q.irq_en |-> !period_match_irq_o)
		else $error("interrupt raised while disabled");
	// the set must win over a clear in the same cycle, so only a quiet cycle is checked
	a_flag_clear: assert property (wr && apb_req_i.paddr == pwm_pkg::ADDR_STAT
		&& apb_req_i.pwdata[pwm_pkg::STAT_FLAG_BIT] && !(s_q.run && period_hit) |=> !s_q.flag)
		else $error("flag not cleared by write");

	a_period_write: assert property (wr && apb_req_i.paddr == pwm_pkg::ADDR_PERIOD
		|=> s_q.pwm_period_reg == $past(apb_req_i.pwdata[CNT_W-1:0]))
		else $error("period write lost");
	a_duty_write: assert property (wr && apb_req_i.paddr == pwm_pkg::ADDR_DUTY
		|=> s_q.duty_buffer_reg == $past(apb_req_i.pwdata[CNT_W-1:0])
		&& s_q.output_terminal_select == $past(apb_req_i.pwdata[pwm_pkg::DUTY_OTS_BIT]))
		else $error("duty write lost");

	a_pin_a_route: assert property (!s_q.output_terminal_select |-> pins_o.pin_a_oe && !pins_o.pin_b_oe
		&& !pins_o.pin_b)
		else $error("pin a routing wrong");
	a_pol_direct: assert property (!s_q.invert |-> (pins_o.pin_a | pins_o.pin_b) == s_q.wave)
		else $error("direct output inverted");
	a_pol_invert: assert property (s_q.invert |-> (pins_o.pin_a | pins_o.pin_b) == !s_q.wave)
		else $error("inverted output not inverted");
endmodule

// File: backlight_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// backlight input: measures high time and cycle length
// --------------------------------------------------------------
module backlight_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic bl_pwm_i,
	output logic [15:0] high_len_o,
	output logic [15:0] cyc_len_o
);
	logic prev_q;
	logic [15:0] hi_q;
	logic [15:0] cyc_q;
	// lengths are latched at each rising edge, so the first report is a partial cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_q <= 1'b0;
			hi_q <= 16'h0000;
			cyc_q <= 16'h0000;
			high_len_o <= 16'h0000;
			cyc_len_o <= 16'h0000;
		end else begin
			prev_q <= bl_pwm_i;
			if (bl_pwm_i && !prev_q) begin
				high_len_o <= hi_q;
				cyc_len_o <= cyc_q;
				hi_q <= 16'h0001;
				cyc_q <= 16'h0001;
			end else begin
				hi_q <= hi_q + {15'h0000, bl_pwm_i};
				cyc_q <= cyc_q + 16'h0001;
			end
		end
	end
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk;
	logic rst_n;
	pwm_pkg::apb_req_s req;
	pwm_pkg::apb_rsp_s rsp;
	pwm_pkg::pwm_pins_s pins;
	logic irq;
	logic [15:0] hi_len;
	logic [15:0] cyc_len;
	logic [31:0] r;
	logic [31:0] r2;
	int hi_cnt;
	int n_fail;
	int checks;
	single_channel_pwm_backlight dut (.core_clk_i(clk), .rst_n_i(rst_n), .apb_req_i(req), .apb_rsp_o(rsp),
		.pins_o(pins), .period_match_irq_o(irq));
	backlight_model bl (.clk_i(clk), .rst_n_i(rst_n), .bl_pwm_i(pins.pin_b), .high_len_o(hi_len),
		.cyc_len_o(cyc_len));
	// --------------------------------------------------------------
	// apb master and compare helpers
	// --------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		req.paddr <= a;
		req.pwrite <= w;
		req.pwdata <= d;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			tally_and_finish();
		end
		r = rsp.prdata;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// --------------------------------------------------------------
	// sequence: period 9 gives ten clocks a cycle, high time duty plus one
	// --------------------------------------------------------------
	initial begin
		n_fail = 0;
		checks = 0;
		rst_n = 1'b0;
		req = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(pwm_pkg::ADDR_PERIOD, 1'b0, 32'h0000_0000);
		chk(r, 32'h0000_03ff);
		apb(pwm_pkg::ADDR_DUTY, 1'b0, 32'h0000_0000);
		chk(r, 32'h0000_0200);
		apb(pwm_pkg::ADDR_PERIOD, 1'b1, 32'h0000_0009);
		apb(pwm_pkg::ADDR_DUTY, 1'b1, 32'h0000_1002);
		apb(pwm_pkg::ADDR_CTRL, 1'b1, 32'h0000_0003);
		repeat (40) @(posedge clk);
		chk({pins.pin_a_oe, pins.pin_b_oe, pins.pin_a}, 32'h0000_0002);
		chk({hi_len, cyc_len}, 32'h0003_000a);
		chk(irq, 32'h0000_0001);
		apb(pwm_pkg::ADDR_DUTY, 1'b1, 32'h0000_1006);
		repeat (40) @(posedge clk);
		chk({hi_len, cyc_len}, 32'h0007_000a);
		apb(pwm_pkg::ADDR_POL, 1'b1, 32'h0000_0001);
		repeat (40) @(posedge clk);
		chk({hi_len, cyc_len}, 32'h0003_000a);
		apb(pwm_pkg::ADDR_STAT, 1'b0, 32'h0000_0000);
		chk(r, 32'h0000_0001);
		apb(pwm_pkg::ADDR_CTRL, 1'b1, 32'h0000_0000);
		apb(pwm_pkg::ADDR_STAT, 1'b1, 32'h0000_0001);
		chk(irq, 32'h0000_0000);
		apb(pwm_pkg::ADDR_STAT, 1'b0, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		apb(pwm_pkg::ADDR_COUNT, 1'b0, 32'h0000_0000);
		r2 = r;
		repeat (7) @(posedge clk);
		apb(pwm_pkg::ADDR_COUNT, 1'b0, 32'h0000_0000);
		chk(r, r2);
		// direct polarity on output a, duty 4 with period 9
		apb(pwm_pkg::ADDR_POL, 1'b1, 32'h0000_0000);
		apb(pwm_pkg::ADDR_DUTY, 1'b1, 32'h0000_0004);
		apb(pwm_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001);
		apb(pwm_pkg::ADDR_COUNT, 1'b0, 32'h0000_0000);
		r2 = r;
		apb(pwm_pkg::ADDR_COUNT, 1'b0, 32'h0000_0000);
		chk(r, (r2 + 32'h0000_0003) % 32'h0000_000a);
		chk({pins.pin_a_oe, pins.pin_b_oe, pins.pin_b}, 32'h0000_0004);
		repeat (30) @(posedge clk);
		hi_cnt = 0;
		repeat (10) begin
			@(posedge clk);
			hi_cnt += pins.pin_a;
		end
		chk(hi_cnt, 32'h0000_0005);
		// reset in mid run
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({pins.pin_a_oe, pins.pin_b_oe, pins.pin_a, irq}, 32'h0000_0008);
		apb(pwm_pkg::ADDR_PERIOD, 1'b0, 32'h0000_0000);
		chk(r, 32'h0000_03ff);
		apb(pwm_pkg::ADDR_CTRL, 1'b0, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		tally_and_finish();
	end
endmodule
